// *** rtl/scp_consts.svh ***
// How it works
// - Bits accepted only while select low
// - Sample serial input on rising clock
// - Commit word on each 24th edge
// - Trailing partial bits discarded, no change
// - Many words per select; read flag carries over
// - Any clock rate up to 20 MHz
// - Write address: A15 zero, A14 one
// - Eight data bits follow the address
// - Read flag blocks writes until cleared
// - Readback shifts D7..D0 out in data phase
// - Output changes on fall, sampled on rise
// - Output high impedance outside readback
// - Reset pulse restores all defaults
// - Reset at most 1000 ns, then wait 100 ns
// - Software reset bit self clears
// - Default 20x; two writes select 40x
// - Host keeps sample rate in limits
// - Sync request high to low starts data
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH
`define SCP_WORD_BITS       24
`define SCP_ADDR_BITS       16
`define SCP_RW_BIT          23
`define SCP_A14_BIT         22
`define SCP_ADDR_SWRST      14'h0006
`define SCP_ADDR_FRAME      14'h002b
`define SCP_ADDR_OCTETS     14'h0030
`define SCP_SWRST_BIT       0
`define SCP_RST_SWRST       8'h00
`define SCP_RST_FRAME       8'h00
`define SCP_RST_OCTETS      8'h00
`define SCP_FRAME_40X       8'h01
`define SCP_OCTETS_40X      8'h11
`define SCP_CLK_NS          4
`define SCP_SCLK_MAX_MHZ    20
`define SCP_SCLK_HALF_NS    (500 / `SCP_SCLK_MAX_MHZ)
`define SCP_SCLK_HALF_CYC   ((`SCP_SCLK_HALF_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_RST_MIN_NS      10
`define SCP_RST_MAX_NS      1000
`define SCP_RST_CYC         (`SCP_RST_MAX_NS / `SCP_CLK_NS)
`define SCP_RST_WAIT_NS     100
`define SCP_RST_WAIT_CYC    ((`SCP_RST_WAIT_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`endif

// *** rtl/scp_pkg.sv ***
package scp_pkg;
  typedef enum logic [3:0] {
    SCP_H_RESET = 4'b0001,
    SCP_H_WAIT  = 4'b0010,
    SCP_H_IDLE  = 4'b0100,
    SCP_H_SHIFT = 4'b1000
  } scp_host_state_t;
endpackage : scp_pkg

// *** rtl/scp_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface scp_if;
  logic serial_select_n;   // Active-low select
  logic sclk;              // Serial clock, host made
  logic serial_in_line;    // Host to device data
  logic serial_out_line;   // Device output value
  logic serial_out_oe;     // Device drives output
  logic hw_reset;          // Active-high device reset
  logic sync_n;            // Sync request, receiver side
  modport dev  (input serial_select_n, sclk, serial_in_line, hw_reset, sync_n,
                output serial_out_line, serial_out_oe);
  modport host (output serial_select_n, sclk, serial_in_line, hw_reset, sync_n,
                input serial_out_line, serial_out_oe);
endinterface : scp_if
`default_nettype wire

// *** rtl/scp_dev.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
module scp_dev
  import scp_pkg::*;
(
  input  wire logic       clk,               // 250 MHz clock
  input  wire logic       rst,               // Sync reset, high
  scp_if.dev              link,              // Serial port pins
  output logic            forty_times_format_q, // 40x format active
  output logic            sending_data_q,    // Out of sync mode
  output logic [7:0]      frame_cfg_q,       // Frame register value
  output logic [7:0]      octets_cfg_q       // Octets register value
);
  logic [1:0] sel_s_q, clk_s_q, din_s_q, hrst_s_q, sync_s_q;
  logic       clk_d1_q;
  logic [4:0] cnt_q;
  logic [23:0] shift_q;
  logic       readback_q;
  logic [7:0] rd_q;
  logic       rd_act_q;
  logic [7:0] swrst_q;
  logic       out_q, oe_q, sync_d1_q;
  logic       rise, fall, sel_act, word_done, hrst, soft_rst;
  logic [23:0] word;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for all pins
  always_ff @(posedge clk) begin
    sel_s_q  <= {sel_s_q[0], link.serial_select_n};
    clk_s_q  <= {clk_s_q[0], link.sclk};
    din_s_q  <= {din_s_q[0], link.serial_in_line};
    hrst_s_q <= {hrst_s_q[0], link.hw_reset};
    sync_s_q <= {sync_s_q[0], link.sync_n};
    clk_d1_q <= clk_s_q[1];
  end

  // Edges from sampled clock; 20 MHz leaves ~6 cycles per phase
  assign rise    = clk_s_q[1] & ~clk_d1_q;
  assign fall    = ~clk_s_q[1] & clk_d1_q;
  assign sel_act = ~sel_s_q[1];
  assign hrst    = hrst_s_q[1];
  assign soft_rst = swrst_q[`SCP_SWRST_BIT];
  assign word    = {shift_q[22:0], din_s_q[1]};
  assign word_done = sel_act & rise & (cnt_q == 5'(`SCP_WORD_BITS - 1));

  ////////////////////////////////////////////////////////////////////
  // Bit counter and shifter
  always_ff @(posedge clk) begin
    if (rst | hrst | ~sel_act) begin
      cnt_q <= 5'h00;
    end else if (rise) begin
      cnt_q <= word_done ? 5'h00 : cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sel_act & rise) begin
      shift_q <= word;
    end
  end

  // Read flag persists across words until a word clears it
  always_ff @(posedge clk) begin
    if (rst | hrst | soft_rst) begin
      readback_q <= 1'b0;
    end else if (word_done) begin
      readback_q <= word[`SCP_RW_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file; writes blocked in readback
  always_ff @(posedge clk) begin
    if (rst | hrst | soft_rst) begin
      swrst_q      <= `SCP_RST_SWRST;
      frame_cfg_q  <= `SCP_RST_FRAME;
      octets_cfg_q <= `SCP_RST_OCTETS;
    end else if (word_done & ~word[`SCP_RW_BIT] & ~readback_q
                 & word[`SCP_A14_BIT]) begin
      case (word[21:8])
        `SCP_ADDR_SWRST:  swrst_q      <= word[7:0];
        `SCP_ADDR_FRAME:  frame_cfg_q  <= word[7:0];
        `SCP_ADDR_OCTETS: octets_cfg_q <= word[7:0];
        default:          ;
      endcase
    end
  end

  // Flag tells the sampler side which rate cap applies
  always_ff @(posedge clk) begin
    if (rst) begin
      forty_times_format_q <= 1'b0;
    end else begin
      forty_times_format_q <= (frame_cfg_q == `SCP_FRAME_40X)
                            & (octets_cfg_q == `SCP_OCTETS_40X);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Readback: address captured at bit 16, data driven on falls
  always_ff @(posedge clk) begin
    if (rst | hrst | ~sel_act) begin
      rd_act_q <= 1'b0;
      rd_q     <= 8'h00;
    end else if (rise & (cnt_q == 5'(`SCP_ADDR_BITS - 1)) & word[15]) begin
      rd_act_q <= 1'b1;
      case (word[13:0])
        `SCP_ADDR_SWRST:  rd_q <= swrst_q;
        `SCP_ADDR_FRAME:  rd_q <= frame_cfg_q;
        `SCP_ADDR_OCTETS: rd_q <= octets_cfg_q;
        default:          rd_q <= 8'h00;
      endcase
    end else if (word_done) begin
      rd_act_q <= 1'b0;
    end else if (rd_act_q & fall & oe_q) begin
      rd_q <= {rd_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst | hrst | ~sel_act | ~rd_act_q) begin
      oe_q  <= 1'b0;
      out_q <= 1'b0;
    end else if (fall) begin
      oe_q  <= 1'b1;
      out_q <= oe_q ? rd_q[6] : rd_q[7];
    end
  end
  assign link.serial_out_line = out_q;
  assign link.serial_out_oe   = oe_q;

  ////////////////////////////////////////////////////////////////////
  // Sync request: high keeps comma mode, fall starts data
  always_ff @(posedge clk) begin
    if (rst | hrst) begin
      sync_d1_q      <= 1'b1;
      sending_data_q <= 1'b0;
    end else begin
      sync_d1_q <= sync_s_q[1];
      if (sync_s_q[1]) begin
        sending_data_q <= 1'b0;
      end else if (sync_d1_q) begin
        sending_data_q <= 1'b1;
      end
    end
  end
endmodule : scp_dev
`default_nettype wire

// *** rtl/scp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
module scp_host
  import scp_pkg::*;
(
  input  wire logic        clk,        // 250 MHz clock
  input  wire logic        rst,        // Sync reset, high
  scp_if.host              link,       // Serial port pins
  input  wire logic        req_valid,  // Access request
  input  wire logic        req_read,   // 1 read, 0 write
  input  wire logic [13:0] req_addr,   // Register address
  input  wire logic [7:0]  req_wdata,  // Write data
  input  wire logic        sync_req_n, // Sync level to drive
  output logic             ready_q,    // Idle, may request
  output logic             done_q,     // Access done pulse
  output logic [7:0]       rdata_q     // Read data
);
  scp_host_state_t st_q;
  logic [9:0]  tmr_q;
  logic [4:0]  bit_q;
  logic [23:0] sh_q;
  logic        sclk_q, sel_n_q, hrst_q, rdflag_q, sync_q;
  logic [1:0]  dout_s_q;

  // Sample returned data through two flops
  always_ff @(posedge clk) begin
    dout_s_q <= {dout_s_q[0], link.serial_out_line};
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer: reset pulse, wait, then 24-bit words
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= SCP_H_RESET; tmr_q <= 10'h000; bit_q <= 5'h00; sh_q <= 24'h000000;
      sclk_q <= 1'b0; sel_n_q <= 1'b1; hrst_q <= 1'b1; ready_q <= 1'b0;
      done_q <= 1'b0; rdata_q <= 8'h00; rdflag_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        SCP_H_RESET: begin
          tmr_q <= tmr_q + 10'h001;
          if (tmr_q == 10'(`SCP_RST_CYC / 2)) begin
            hrst_q <= 1'b0; tmr_q <= 10'h000; st_q <= SCP_H_WAIT;
          end
        end
        SCP_H_WAIT: begin
          tmr_q <= tmr_q + 10'h001;
          if (tmr_q == 10'(`SCP_RST_WAIT_CYC)) begin
            st_q <= SCP_H_IDLE; ready_q <= 1'b1;
          end
        end
        SCP_H_IDLE: begin
          if (req_valid) begin
            // Read flag, A14 set, address, data; MSB first
            sh_q <= {req_read, 1'b1, req_addr, req_read ? 8'h00 : req_wdata};
            rdflag_q <= req_read;
            sel_n_q <= 1'b0; ready_q <= 1'b0; bit_q <= 5'h00; tmr_q <= 10'h000;
            st_q <= SCP_H_SHIFT;
          end
        end
        SCP_H_SHIFT: begin
          // Half period of at least 25 ns keeps clock at or under 20 MHz
          tmr_q <= tmr_q + 10'h001;
          if (tmr_q == 10'(`SCP_SCLK_HALF_CYC * 2)) begin
            tmr_q <= 10'h000;
            if (!sclk_q) begin
              if (bit_q == 5'(`SCP_WORD_BITS)) begin
                sel_n_q <= 1'b1; ready_q <= 1'b1; done_q <= 1'b1;
                st_q <= SCP_H_IDLE;
              end else begin
                sclk_q <= 1'b1;
                // Line now holds the bit launched on the last fall, D7 first
                if (rdflag_q & bit_q >= 5'(`SCP_ADDR_BITS))
                  rdata_q <= {rdata_q[6:0], dout_s_q[1]};
                bit_q <= bit_q + 5'h01;
              end
            end else begin
              sclk_q <= 1'b0;
              sh_q <= {sh_q[22:0], 1'b0};
            end
          end
        end
        default: st_q <= SCP_H_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) sync_q <= 1'b1;
    else     sync_q <= sync_req_n;
  end

  assign link.sclk            = sclk_q;
  assign link.serial_select_n = sel_n_q;
  assign link.serial_in_line  = sh_q[23];
  assign link.hw_reset        = hrst_q;
  assign link.sync_n          = sync_q;
endmodule : scp_host
`default_nettype wire

// *** verif/scp_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module scp_chk (
  input wire logic clk,             // 250 MHz clock
  input wire logic rst,             // Sync reset, high
  input wire logic serial_select_n, // Select, low active
  input wire logic sclk,            // Serial clock
  input wire logic serial_in_line,  // Host data
  input wire logic serial_out_line, // Device data
  input wire logic serial_out_oe,   // Device drives output
  input wire logic hw_reset,        // Device reset pin
  input wire logic sync_n           // Sync request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] rise_cnt_q;  // Serial rises in this select
  logic [7:0] since_rise_q;
  logic [7:0] since_hw_q;
  logic [8:0] hw_len_q;
  logic       sclk_q;
  ////////////////////////////////////////////////////////////////
  // Edge counters; timers saturate so long idle never wraps, rise count clears on deselect
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    if (rst || serial_select_n) rise_cnt_q <= 5'h00;
    else if (sclk && !sclk_q) rise_cnt_q <= rise_cnt_q + 5'h01;
    if (rst) since_rise_q <= 8'hff;
    else if (sclk && !sclk_q) since_rise_q <= 8'h00;
    else if (since_rise_q != 8'hff) since_rise_q <= since_rise_q + 8'h01;
    if (rst || hw_reset) since_hw_q <= 8'h00;
    else if (since_hw_q != 8'hff) since_hw_q <= since_hw_q + 8'h01;
    if (rst || !hw_reset) hw_len_q <= 9'h000;
    else if (hw_len_q != 9'h1ff) hw_len_q <= hw_len_q + 9'h001;
  end
  ////////////////////////////////////////////////////////////////
  a_oe_needs_select: assert property (serial_out_oe |-> !serial_select_n)
    else $error("output driven while deselected");
  a_oe_drops_deselect: assert property ($rose(serial_select_n) |-> ##[0:4] !serial_out_oe)
    else $error("output still driven after deselect");
  a_out_after_addr: assert property ($rose(serial_out_oe) |-> rise_cnt_q == 5'd16)
    else $error("readback started at wrong bit");
  a_out_stable_high: assert property (sclk && $past(sclk) && serial_out_oe && $past(serial_out_oe)
    |-> $stable(serial_out_line))
    else $error("output changed while serial clock high");
  a_word_24_rises: assert property ($rose(serial_select_n) |-> rise_cnt_q == 5'd24)
    else $error("word length not 24 bits");
  a_sclk_max_rate: assert property ($rose(sclk) |-> since_rise_q >= 8'd12)
    else $error("serial clock above 20 MHz");
  a_hw_pulse_min: assert property ($fell(hw_reset) |-> $past(hw_reset, 3))
    else $error("reset pulse too short");
  a_hw_pulse_max: assert property (hw_len_q <= 9'd250)
    else $error("reset pulse too long");
  // 25 cycles of 4 ns cover the 100 ns gap after reset
  a_wait_after_rst: assert property ($fell(serial_select_n) |-> since_hw_q >= 8'd25)
    else $error("select too soon after reset");
  // Second bit of every word is the address marker, sampled at its rise
  a_addr_marker: assert property ($rose(sclk) && rise_cnt_q == 5'd1 |-> serial_in_line)
    else $error("address marker bit not set");
  a_sync_in_rst: assert property (hw_reset |-> sync_n)
    else $error("sync request low during reset");
endmodule // scp_chk
`default_nettype wire

// *** verif/serial_config_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_config_port_tb;
  import scp_pkg::*;
  typedef struct packed {logic rd; logic [13:0] addr; logic [7:0] wd; logic [7:0] exp;
    logic fmt;} scp_row_t;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_read = 1'b0, sync_req_n = 1'b1;
  logic [13:0] req_addr = 14'h0000;
  logic [7:0]  req_wdata = 8'h00, rdata_q, frame_cfg_q, octets_cfg_q;
  logic ready_q, done_q, forty_times_format_q, sending_data_q;
  int num_errors = 0, n_compared = 0, cyc = 0;
  scp_row_t rows [14];
  scp_if scp_if_inst ();
  scp_dev scp_dev_inst (.clk(clk), .rst(rst), .link(scp_if_inst.dev),
    .forty_times_format_q(forty_times_format_q), .sending_data_q(sending_data_q),
    .frame_cfg_q(frame_cfg_q), .octets_cfg_q(octets_cfg_q));
  scp_host scp_host_inst (.clk(clk), .rst(rst), .link(scp_if_inst.host), .req_valid(req_valid),
    .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata), .sync_req_n(sync_req_n),
    .ready_q(ready_q), .done_q(done_q), .rdata_q(rdata_q));
  scp_chk scp_chk_inst (.clk(clk), .rst(rst), .serial_select_n(scp_if_inst.serial_select_n),
    .sclk(scp_if_inst.sclk), .serial_in_line(scp_if_inst.serial_in_line),
    .serial_out_line(scp_if_inst.serial_out_line), .serial_out_oe(scp_if_inst.serial_out_oe),
    .hw_reset(scp_if_inst.hw_reset), .sync_n(scp_if_inst.sync_n));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded waits; a stuck handshake is a mismatch, not a hang
  task automatic wait_ready();
    int n;
    for (n = 0; n < 1000 && ready_q !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, ready_q}, 8'h01);
  endtask
  task automatic access(input logic rd, input logic [13:0] addr, input logic [7:0] wd);
    int n;
    wait_ready();
    req_valid = 1'b1;
    req_read = rd;
    req_addr = addr;
    req_wdata = wd;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    for (n = 0; n < 2000 && done_q !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, done_q}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence: table of accesses, then reset and sync cases
  initial begin
    // After a read, the next write word is refused and only clears the read flag;
    // rows 2, 5, 8 and 13 are such refused words, row 3 proves nothing landed
    rows[0]  = '{1'b0, 14'h002b, 8'h01, 8'h00, 1'b0};
    rows[1]  = '{1'b1, 14'h002b, 8'h00, 8'h01, 1'b0};
    rows[2]  = '{1'b0, 14'h0030, 8'h11, 8'h00, 1'b0};
    rows[3]  = '{1'b1, 14'h0030, 8'h00, 8'h00, 1'b0};
    rows[4]  = '{1'b1, 14'h0015, 8'h00, 8'h00, 1'b0};
    rows[5]  = '{1'b0, 14'h0030, 8'h11, 8'h00, 1'b0};
    rows[6]  = '{1'b0, 14'h0030, 8'h11, 8'h00, 1'b1};
    rows[7]  = '{1'b1, 14'h0030, 8'h00, 8'h11, 1'b1};
    rows[8]  = '{1'b0, 14'h0015, 8'h00, 8'h00, 1'b1};
    rows[9]  = '{1'b0, 14'h0006, 8'h01, 8'h00, 1'b0};
    rows[10] = '{1'b1, 14'h0006, 8'h00, 8'h00, 1'b0};
    rows[11] = '{1'b1, 14'h002b, 8'h00, 8'h00, 1'b0};
    rows[12] = '{1'b1, 14'h0030, 8'h00, 8'h00, 1'b0};
    rows[13] = '{1'b0, 14'h0015, 8'h00, 8'h00, 1'b0};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    wait_ready();
    chk({7'h00, forty_times_format_q}, 8'h00);
    chk(frame_cfg_q, 8'h00);
    chk(octets_cfg_q, 8'h00);
    chk({7'h00, sending_data_q}, 8'h00);
    foreach (rows[i]) begin
      access(rows[i].rd, rows[i].addr, rows[i].wd);
      if (rows[i].rd) chk(rdata_q, rows[i].exp);
      chk({7'h00, forty_times_format_q}, {7'h00, rows[i].fmt});
    end
    // Mid-run reset must bring 40x back to the default format
    access(1'b0, 14'h002b, 8'h01);
    access(1'b0, 14'h0030, 8'h11);
    chk({7'h00, forty_times_format_q}, 8'h01);
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    wait_ready();
    chk(frame_cfg_q, 8'h00);
    chk({7'h00, forty_times_format_q}, 8'h00);
    // Sync request falling edge starts data, raising it again stops it
    sync_req_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 chk({7'h00, sending_data_q}, 8'h01);
    sync_req_n = 1'b1;
    repeat (20) @(posedge clk);
    #1 chk({7'h00, sending_data_q}, 8'h00);
    end_sim();
  end
endmodule // serial_config_port_tb
`default_nettype wire
